// ### eight_bit_interval_timer_bench.sv
// Self-checking bench for the eight-bit interval timer.
`timescale 1ns/1ps
`include "it8_consts.svh"
module eight_bit_interval_timer_bench;
  import it8_pkg::*;
  // ---------------------------------------------------------------
  // Register byte addresses and bench signals.
  // ---------------------------------------------------------------
  localparam logic [11:0] A_MODE = {`IT8_MODE_IDX, 2'b00};
  localparam logic [11:0] A_CNT  = {`IT8_COUNT_IDX, 2'b00};
  localparam logic [11:0] A_IRQ  = {`IT8_IRQ_IDX, 2'b00};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr  = '0;
  logic [31:0] pwdata = '0;
  logic [3:0]  pstrb  = 4'hf;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, timer_irq, wake_req, err;
  logic        rtc_clk = 0, rtc_on = 0, opt = 0, green_mode = 0;
  int          mismatches = 0, compares = 0, cyc = 0, n, w, v;
  int          mdl_q[$];  // Model: expected readback of each register.
  // Clock; the slow source is stepped from the cycle counter below.
  always #25 pclk = ~pclk;
  it8_timer it8_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk(rtc_clk), .internal_rc_with_rtc_option(opt),
    .green_mode(green_mode), .timer_irq(timer_irq), .wake_req(wake_req));
  // A hang is cut short here and counted as a mismatch.
  // The slow source toggles every third cycle while a test asks for it.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (rtc_on && cyc % 3 == 0)
    begin
      rtc_clk <= ~rtc_clk;
    end
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // One APB transfer; waits for pready rather than assuming a latency.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Ends when pready is seen; only the bench timeout ends a hang.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : apb
  // Compare with case equality so an unknown never matches.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Count cycles until the request shows; wake pulses are tallied too.
  task automatic wait_irq(input int lim);
    n = 0;
    w = 0;
    while (timer_irq !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
      if (wake_req === 1'b1) w++;
    end
  endtask : wait_irq
  task automatic finish_test();
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(38));
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    mdl_q = '{0, 0, 0};
    apb(0, A_MODE, 0); chk(rd, mdl_q[0]);
    apb(0, A_CNT, 0); chk(rd, mdl_q[1]);
    apb(0, 12'h004, 0); chk(rd, 0);
    chk(err, 1);
    // Random mode and count with the run bit off; bits 3:1 read zero.
    v = $urandom & 32'h7f;
    mdl_q[0] = v & 32'h71;
    apb(1, A_MODE, v); apb(0, A_MODE, 0); chk(rd, mdl_q[0]);
    v = $urandom;
    mdl_q[1] = v & 32'hff;
    apb(1, A_CNT, v);
    // A write without the low byte strobe must leave the count alone.
    pstrb <= 4'he;
    apb(1, A_CNT, ~v);
    pstrb <= 4'hf;
    repeat (600) @(posedge pclk);
    apb(0, A_CNT, 0); chk(rd, mdl_q[1]);
    // Every prescale code, two steps from the wrap; green in one case.
    for (int c = 0; c < 8; c++)
    begin
      green_mode <= (c == 3);
      apb(1, A_MODE, c << 4);
      apb(1, A_IRQ, 0);
      apb(1, A_CNT, 32'hfe);
      apb(1, A_IRQ, 32'h2);
      apb(1, A_MODE, 32'h80 | (c << 4));
      wait_irq(1200);
      chk(n >= (256 >> c) - 1 && n <= (512 >> c) + 4, 1);
      chk(w, c == 3);
      apb(0, A_CNT, 0); chk(rd < 8, 1);
    end
    // Stop, then mask, then clear the request.
    apb(1, A_MODE, 0);
    apb(1, A_IRQ, 32'h1);
    @(posedge pclk);
    chk(timer_irq, 0);
    apb(0, A_IRQ, 0); chk(rd, 1);
    apb(1, A_IRQ, 0); apb(0, A_IRQ, 0); chk(rd, 0);
    // Slow source without the option strap: the count must not move.
    apb(1, A_CNT, 32'hfe);
    apb(1, A_IRQ, 32'h2);
    apb(1, A_MODE, 32'hf1);
    rtc_on <= 1;
    repeat (1000) @(posedge pclk);
    apb(0, A_CNT, 0); chk(rd, 32'hfe);
    // With the strap, one step per 64 slow edges; rate is ignored.
    opt <= 1;
    wait_irq(2000);
    chk(n >= 380 && n <= 820, 1);
    // Wait 330 cycles, under one 384-cycle count step, before the flag is cleared.
    repeat (330) @(posedge pclk);
    apb(1, A_IRQ, 32'h2);
    apb(0, A_IRQ, 0); chk(rd, 2);
    chk(timer_irq, 0);
    rtc_on <= 0;
    finish_test();
  end
endmodule : eight_bit_interval_timer_bench

// ### it8_consts.svh
// Register map, field positions, reset values and timing counts.
// Summary of operation
// - Eight-bit up counter; wrap raises time-out request.
// - Mode bit 7 runs or stops counting.
// - Bits 6:4 divide clock 256 down to 2.
// - Mode bit 0 selects real-time clock source.
// - RTC mode ignores rate; half-second full cycle.
// - RTC mode works only with option strap.
// - Enabled timer overflow wakes system from green.
// - Count register readable, writable, resets to zero.
`ifndef IT8_CONSTS_SVH
`define IT8_CONSTS_SVH
// -----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// -----------------------------------------------------------------------
`define IT8_MODE_IDX      10'h0d8
`define IT8_COUNT_IDX     10'h0d9
`define IT8_IRQ_IDX       10'h0f0
// -----------------------------------------------------------------------
// Field positions and reset values.
// -----------------------------------------------------------------------
`define IT8_RUN_BIT       7
`define IT8_RATE_MSB      6
`define IT8_RATE_LSB      4
`define IT8_RTC_BIT       0
`define IT8_FLAG_BIT      0
`define IT8_IEN_BIT       1
`define IT8_MODE_RST      8'h00
`define IT8_COUNT_RST     8'h00
// -----------------------------------------------------------------------
// Timing: RTC source rate and the half-second full-cycle interval.
// -----------------------------------------------------------------------
`define IT8_RTC_HZ        32768
`define IT8_RTC_PER_SEC   2
`define IT8_FULL_COUNTS   256
`define IT8_RTC_DIV       (`IT8_RTC_HZ / (`IT8_RTC_PER_SEC * `IT8_FULL_COUNTS))
`endif

// ### it8_pkg.sv
// Types shared by the interval timer.
package it8_pkg;
  // Decoded mode register fields.
  typedef struct packed {
    logic       run;   // Counting allowed.
    logic [2:0] rate;  // Prescale code.
    logic       rtc;   // Real-time clock source.
  } it8_mode_t;
  // Interrupt control and status.
  typedef struct packed {
    logic ien;   // Request enable.
    logic flag;  // Sticky request.
  } it8_irq_t;
endpackage : it8_pkg

// ### it8_timer.sv
// Eight-bit interval timer with APB register access.
`timescale 1ns/1ps
`include "it8_consts.svh"
module it8_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rtc_clk,
  input  wire logic        internal_rc_with_rtc_option,
  input  wire logic        green_mode,
  output logic             timer_irq,
  output logic             wake_req
);
  import it8_pkg::*;

  localparam int RTC_DIV = `IT8_RTC_DIV;
  // Reset image of the mode register. It is split into its fields at reset
  // so that only the bits the register really holds are loaded.
  localparam logic [7:0] MODE_RST = `IT8_MODE_RST;

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  it8_pkg::it8_mode_t mode_ff, nxt_mode;      // Mode register fields.
  it8_pkg::it8_irq_t  irq_ff, nxt_irq;        // Flag and enable.
  logic [7:0]  cnt_ff, nxt_cnt;                // Count register.
  logic [7:0]  presc_ff, nxt_presc;            // Free CPU-clock divider.
  logic [5:0]  rdiv_ff, nxt_rdiv;              // RTC edge divider.
  logic [2:0]  rsync_ff;                       // RTC sync plus edge stage.
  logic [1:0]  osync_ff;                       // Option strap sync.
  logic [31:0] prdata_ff, nxt_prdata;          // Read data.
  logic        pready_ff, nxt_pready;          // Access answer.
  logic        perr_ff, nxt_perr;              // Unmapped answer.
  logic        irq_ff_out, nxt_irq_out;        // Interrupt line.
  logic        wake_ff, nxt_wake;              // Wake pulse.

  // -----------------------------------------------------------------------
  // Decode.
  // -----------------------------------------------------------------------
  logic [9:0] idx;       // Word index of the access.
  logic       hit_mode;  // Mode register selected.
  logic       hit_cnt;   // Count register selected.
  logic       hit_irq;   // Interrupt register selected.
  logic       mapped;    // Any register selected.
  logic       wr_go;     // Write completes this edge.
  logic       cpu_tick;  // Prescaled CPU clock tick.
  logic       rtc_edge;  // Rising edge of synced RTC clock.
  logic       rtc_tick;  // One count step in RTC mode.
  logic       inc;       // Counter steps this edge.
  logic       ovf;       // Counter wraps this edge.
  logic       wr_cnt;    // Software loads the count.

  assign idx      = paddr[11:2];
  assign hit_mode = (idx == `IT8_MODE_IDX);
  assign hit_cnt  = (idx == `IT8_COUNT_IDX);
  assign hit_irq  = (idx == `IT8_IRQ_IDX);
  assign mapped   = (hit_mode | hit_cnt | hit_irq) & (paddr[1:0] == 2'h0);
  // The answer is already up in the first access cycle, so no wait states.
  assign wr_go    = psel & penable & pready_ff & pwrite & mapped & pstrb[0];
  assign wr_cnt   = wr_go & hit_cnt;

  // The prescaler runs free; a code picks how many low bits must be ones.
  assign cpu_tick = ((presc_ff & (8'hff >> mode_ff.rate))
                     == (8'hff >> mode_ff.rate));
  assign rtc_edge = rsync_ff[1] & ~rsync_ff[2];
  // Sixty-four RTC edges per step give 256 steps per half second.
  assign rtc_tick = rtc_edge & (rdiv_ff == 6'(RTC_DIV - 1));
  // Without the strap the RTC source is dead and the counter stalls.
  assign inc = mode_ff.run & (mode_ff.rtc ? (rtc_tick & osync_ff[1])
                                          : cpu_tick);
  assign ovf = inc & (cnt_ff == 8'hff) & ~wr_cnt;

  // -----------------------------------------------------------------------
  // Next-state logic for timer, registers and bus answer.
  // -----------------------------------------------------------------------
  always_comb
  begin
    nxt_presc = presc_ff + 8'h01;
    nxt_rdiv  = rdiv_ff;
    if (rtc_edge)
    begin
      nxt_rdiv = rdiv_ff + 6'h01;
    end
    nxt_mode = mode_ff;
    nxt_irq  = irq_ff;
    nxt_cnt  = cnt_ff;
    // Counting wraps and carries on; no reload value exists.
    if (inc)
    begin
      nxt_cnt = cnt_ff + 8'h01;
    end
    if (wr_go && hit_mode)
    begin
      nxt_mode.run  = pwdata[`IT8_RUN_BIT];
      nxt_mode.rate = pwdata[`IT8_RATE_MSB:`IT8_RATE_LSB];
      nxt_mode.rtc  = pwdata[`IT8_RTC_BIT];
    end
    // A load wins over a step in the same cycle.
    if (wr_cnt)
    begin
      nxt_cnt = pwdata[7:0];
    end
    if (wr_go && hit_irq)
    begin
      nxt_irq.ien  = pwdata[`IT8_IEN_BIT];
      nxt_irq.flag = irq_ff.flag & pwdata[`IT8_FLAG_BIT];
    end
    // Set beats a clear arriving in the same cycle.
    if (ovf)
    begin
      nxt_irq.flag = 1'b1;
    end
    nxt_irq_out = nxt_irq.flag & nxt_irq.ien;
    nxt_wake    = ovf & green_mode & mode_ff.run;
    // Answer is prepared in the setup cycle and shown in the access cycle.
    nxt_pready = psel & ~penable;
    nxt_perr   = psel & ~penable & ~mapped;
    nxt_prdata = prdata_ff;
    if (psel && !penable)
    begin
      nxt_prdata = 32'h0;
      if (hit_mode && mapped)
      begin
        nxt_prdata[`IT8_RUN_BIT] = mode_ff.run;
        nxt_prdata[`IT8_RATE_MSB:`IT8_RATE_LSB] = mode_ff.rate;
        nxt_prdata[`IT8_RTC_BIT] = mode_ff.rtc;
      end
      else if (hit_cnt && mapped)
      begin
        nxt_prdata[7:0] = cnt_ff;
      end
      else if (hit_irq && mapped)
      begin
        nxt_prdata[`IT8_FLAG_BIT] = irq_ff.flag;
        nxt_prdata[`IT8_IEN_BIT]  = irq_ff.ien;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Registers.
  // -----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff    <= '{run:  MODE_RST[`IT8_RUN_BIT],
                      rate: MODE_RST[`IT8_RATE_MSB:`IT8_RATE_LSB],
                      rtc:  MODE_RST[`IT8_RTC_BIT]};
      irq_ff     <= 2'h0;
      cnt_ff     <= `IT8_COUNT_RST;
      presc_ff   <= 8'h00;
      rdiv_ff    <= 6'h00;
      rsync_ff   <= 3'h0;
      osync_ff   <= 2'h0;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      perr_ff    <= 1'b0;
      irq_ff_out <= 1'b0;
      wake_ff    <= 1'b0;
    end
    else
    begin
      mode_ff    <= nxt_mode;
      irq_ff     <= nxt_irq;
      cnt_ff     <= nxt_cnt;
      presc_ff   <= nxt_presc;
      rdiv_ff    <= nxt_rdiv;
      rsync_ff   <= {rsync_ff[1:0], rtc_clk};
      osync_ff   <= {osync_ff[0], internal_rc_with_rtc_option};
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      perr_ff    <= nxt_perr;
      irq_ff_out <= nxt_irq_out;
      wake_ff    <= nxt_wake;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = perr_ff;
  assign timer_irq = irq_ff_out;
  assign wake_req  = wake_ff;

  // -----------------------------------------------------------------------
  // Assertions.
  // -----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wrap_sets_flag: assert property
    (ovf |=> irq_ff.flag && cnt_ff == 8'h00)
    else $error("wrap did not raise flag");
  a_stop_holds: assert property
    (!mode_ff.run && !wr_cnt |=> $stable(cnt_ff))
    else $error("stopped counter moved");
  // The window covers both edges that may step the counter, so exactly
  // one divide-by-two tick falls inside it.
  a_rate_fastest: assert property
    ((mode_ff.run && !mode_ff.rtc && mode_ff.rate == 3'h7 && !wr_cnt)[*2]
     |=> cnt_ff == 8'($past(cnt_ff, 2) + 8'h01))
    else $error("divide by two step wrong");
  a_rtc_ignores_cpu: assert property
    (mode_ff.rtc && !rtc_tick && !wr_cnt |=> $stable(cnt_ff))
    else $error("rtc mode stepped on cpu tick");
  a_rtc_strap: assert property
    (mode_ff.rtc && !osync_ff[1] |-> !inc)
    else $error("rtc mode ran without strap");
  a_green_wake: assert property
    (ovf && green_mode && mode_ff.run |=> wake_req ##1 !wake_req)
    else $error("no single wake pulse");
  // A load also swallows a wrap, so the request flag must hold still.
  a_count_load: assert property
    (wr_cnt |=> cnt_ff == $past(pwdata[7:0]) && $stable(irq_ff.flag))
    else $error("count load lost");
  a_irq_line: assert property
    (ovf && irq_ff.ien && !(wr_go && hit_irq) |=> ##[0:1] timer_irq)
    else $error("interrupt line not raised");
endmodule : it8_timer
